// File: bench/tamper_alarm_monitor_sva.sv
`timescale 1ns/10ps
module tam_chk
#(
	parameter int unsigned RESET_TIMEOUT_CYCLES = 8
)
(
	input wire logic clk, // Clock.
	input wire logic rst_n, // Reset.
	input wire logic tamper_in_a_idle_high, // Loop a.
	input wire logic tamper_in_b_idle_low, // Loop b.
	input wire logic tamper_in_c_idle_high, // Loop c.
	input wire logic tamper_in_d_idle_low, // Loop d.
	input wire logic overvoltage_trip, // Over.
	input wire logic undervoltage_trip, // Under.
	input wire logic main_above_reset, // Main ok.
	input wire tamper_pkg::supply_variant_e variant, // Mode.
	input wire logic [7:0] filter_count, // Samples.
	input wire logic security_alarm_n, // Alarm.
	input wire logic supply_on, // Switch.
	input wire logic supply_gnd, // Ground.
	input wire logic switch_ind, // Indicator.
	input wire logic detect_armed // Armed.
);
	import tamper_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [3:0] tv, tv_q;
	logic [9:0] run_q, quiet_q, main_q;
	// Bit set where a loop sits away from its idle level.
	assign tv = {tamper_in_d_idle_low, ~tamper_in_c_idle_high,
		tamper_in_b_idle_low, ~tamper_in_a_idle_high};
	always_ff @(posedge clk)
	begin
		tv_q <= tv;
		run_q <= (rst_n && tv != 4'h0 && tv == tv_q) ? run_q + 10'h1 : 10'h0;
		quiet_q <= (rst_n && tv == 4'h0 && !overvoltage_trip && !undervoltage_trip) ?
			quiet_q + 10'h1 : 10'h0;
		main_q <= (rst_n && main_above_reset) ? main_q + 10'h1 : 10'h0;
	end
	property p_idle; !detect_armed |=> security_alarm_n; endproperty
	a_idle: assert property (p_idle) else $error("alarm while unarmed");
	property p_keep; detect_armed |=> detect_armed; endproperty
	a_keep: assert property (p_keep) else $error("arming lost");
	property p_early; $rose(detect_armed) |-> main_q >= RESET_TIMEOUT_CYCLES; endproperty
	a_early: assert property (p_early) else $error("armed too early");
	property p_late; main_q == RESET_TIMEOUT_CYCLES + 8 |-> detect_armed; endproperty
	a_late: assert property (p_late) else $error("armed too late");
	property p_volt;
		(detect_armed && (overvoltage_trip || undervoltage_trip))[*4] |=> !security_alarm_n;
	endproperty
	a_volt: assert property (p_volt) else $error("supply fault missed");
	property p_tamp; detect_armed && run_q > filter_count + 4 |-> !security_alarm_n; endproperty
	a_tamp: assert property (p_tamp) else $error("tamper missed");
	property p_rel; quiet_q > filter_count + 4 |-> security_alarm_n; endproperty
	a_rel: assert property (p_rel) else $error("alarm held");
	property p_norm; security_alarm_n |-> supply_on && !supply_gnd; endproperty
	a_norm: assert property (p_norm) else $error("supply off at rest");
	property p_var;
		!security_alarm_n && $stable(variant) && variant inside {VARIANT_HIZ, VARIANT_GND}
			|-> switch_ind && !supply_on && supply_gnd == (variant == VARIANT_GND);
	endproperty
	a_var: assert property (p_var) else $error("variant supply wrong");
endmodule : tam_chk

bind tamper_alarm_monitor tam_chk #(.RESET_TIMEOUT_CYCLES(RESET_TIMEOUT_CYCLES)) u_chk
(
	.clk, .rst_n, .tamper_in_a_idle_high, .tamper_in_b_idle_low, .tamper_in_c_idle_high,
	.tamper_in_d_idle_low, .overvoltage_trip, .undervoltage_trip, .main_above_reset, .variant,
	.filter_count, .security_alarm_n, .supply_on, .supply_gnd, .switch_ind, .detect_armed
);

// File: bench/tamper_mesh.sv
`timescale 1ns/10ps
module tamper_mesh
(
	input  wire logic [3:0] cut,                   // Opened loops.
	output logic            tamper_in_a_idle_high, // Pulled up.
	output logic            tamper_in_b_idle_low,  // Pulled down.
	output logic            tamper_in_c_idle_high, // Pulled up.
	output logic            tamper_in_d_idle_low   // Pulled down.
);
	assign tamper_in_a_idle_high = ~cut[0];
	assign tamper_in_b_idle_low  = cut[1];
	assign tamper_in_c_idle_high = ~cut[2];
	assign tamper_in_d_idle_low  = cut[3];
endmodule : tamper_mesh

// File: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import tamper_pkg::*;
	logic clk, rst_n, overvoltage_trip, undervoltage_trip, main_above_reset, on_battery;
	logic tamper_in_a_idle_high, tamper_in_b_idle_low, tamper_in_c_idle_high, tamper_in_d_idle_low;
	logic security_alarm_n, supply_on, supply_gnd, switch_ind, detect_armed;
	logic [7:0] filter_count;
	logic [3:0] cut;
	logic [15:0] lfsr;
	supply_variant_e variant;
	int mismatches, check_count, cyc;
	tamper_alarm_monitor #(.RESET_TIMEOUT_CYCLES(8)) u_dut
	(
		.clk, .rst_n, .tamper_in_a_idle_high, .tamper_in_b_idle_low, .tamper_in_c_idle_high,
		.tamper_in_d_idle_low, .overvoltage_trip, .undervoltage_trip, .main_above_reset,
		.on_battery, .variant, .filter_count, .security_alarm_n, .supply_on, .supply_gnd,
		.switch_ind, .detect_armed
	);
	tamper_mesh u_mesh (.cut, .tamper_in_a_idle_high, .tamper_in_b_idle_low,
		.tamper_in_c_idle_high, .tamper_in_d_idle_low);
	function automatic logic [15:0] step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : step
	function automatic logic [3:0] exp_out(input logic al);
		if (al && variant inside {VARIANT_HIZ, VARIANT_GND})
			return {2'b00, variant == VARIANT_GND, 1'b1};
		return {~al, 2'b10, on_battery};
	endfunction : exp_out
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic check_out(input logic al);
		check({security_alarm_n, supply_on, supply_gnd, switch_ind}, exp_out(al));
	endtask : check_out
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_n
	task automatic finish_test;
		if (mismatches == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			mismatches++;
			finish_test();
		end
	end
	initial
	begin
		{rst_n, cut, overvoltage_trip, undervoltage_trip, main_above_reset} = 8'h24;
		on_battery = 1'b1;
		variant = VARIANT_ON;
		{filter_count, lfsr} = {8'h03, 16'hBBD6};
		wait_n(3);
		rst_n <= 1'b1;
		main_above_reset <= 1'b1;
		wait_n(6);
		main_above_reset <= 1'b0;
		wait_n(2);
		check({3'h0, security_alarm_n}, 4'h1);
		{cut, overvoltage_trip, main_above_reset} <= 6'h01;
		wait_n(10);
		check({3'h0, detect_armed}, 4'h0);
		wait_n(6);
		check({3'h0, detect_armed}, 4'h1);
		for (int v = 0; v < 4; v++)
		begin
			lfsr = step(lfsr);
			variant <= supply_variant_e'(v[1:0]);
			on_battery <= lfsr[0];
			cut <= (4'h1 << v) | lfsr[4:1];
			wait_n(12);
			check_out(1'b1);
			cut <= 4'h0;
			wait_n(12);
			check_out(1'b0);
			cut <= 4'h1 << lfsr[6:5];
			wait_n(2);
			cut <= 4'h0;
			repeat (12)
			begin
				wait_n(1);
				check({3'h0, security_alarm_n}, 4'h1);
			end
			{overvoltage_trip, undervoltage_trip} <= lfsr[7] ? 2'b10 : 2'b01;
			wait_n(5);
			check_out(1'b1);
			{overvoltage_trip, undervoltage_trip} <= 2'b00;
			wait_n(5);
			check_out(1'b0);
		end
		{main_above_reset, on_battery, cut} <= 6'h18;
		wait_n(12);
		check({security_alarm_n, 2'h0, detect_armed}, 4'h1);
		finish_test();
	end
endmodule : tb_top

// File: pkg/tamper_cfg.svh
`ifndef TAMPER_CFG_SVH
`define TAMPER_CFG_SVH

// Tamper input order in the input vector.
`define TAMPER_A_BIT      0
`define TAMPER_B_BIT      1
`define TAMPER_C_BIT      2
`define TAMPER_D_BIT      3
// Idle level of each input, bit per input: a and c high, b and d low.
`define TAMPER_IDLE_LEVEL 4'h5
// Default number of stable samples before a level counts.
`define FILTER_COUNT_RST  8'h10
// Reset time-out in microseconds and derived cycles at 20 MHz.
`define RESET_TIMEOUT_US  200
`define CLK_MHZ           20
`define RESET_TIMEOUT_CYC (`RESET_TIMEOUT_US * `CLK_MHZ)

`endif

// File: pkg/tamper_pkg.sv
package tamper_pkg;

	typedef enum logic [1:0]
	{
		VARIANT_ON   = 2'h0,
		VARIANT_HIZ  = 2'h1,
		VARIANT_GND  = 2'h2
	} supply_variant_e;

	typedef struct packed
	{
		logic [3:0] tamper_in;
		logic       overvoltage_trip;
		logic       undervoltage_trip;
	} sense_s;

	typedef struct packed
	{
		logic supply_on;
		logic supply_oe;
		logic switch_ind;
	} supply_ctl_s;

	typedef enum logic [2:0]
	{
		ARM_COLD    = 3'b001,
		ARM_TIMEOUT = 3'b010,
		ARM_ARMED   = 3'b100
	} arm_state_e;

endpackage : tamper_pkg

// File: verilog/glitch_filter.sv
`timescale 1ns/10ps
`include "tamper_cfg.svh"

module glitch_filter
(
	input  wire logic       clk,        // System clock.
	input  wire logic       rst_n,      // Synchronous reset, active low.
	input  wire logic       raw_in,     // Raw asynchronous-origin level.
	input  wire logic       reset_val,  // Idle level taken at reset.
	input  wire logic [7:0] stable_cnt, // Samples required before change.
	output logic            filt_out    // Filtered level.
);
	logic       sync1_q;
	logic       sync2_q;
	logic [7:0] cnt_q;

	// Two flops bring the level into the clock domain.
	always_ff @(posedge clk)
	begin
		sync1_q <= raw_in;
		sync2_q <= sync1_q;
	end

	// The output follows only after stable_cnt + 1 agreeing samples.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_q    <= 8'h00;
			filt_out <= reset_val;
		end
		else if (sync2_q == filt_out)
			cnt_q <= 8'h00;
		else if (cnt_q >= stable_cnt)
		begin
			filt_out <= sync2_q;
			cnt_q    <= 8'h00;
		end
		else
			cnt_q <= cnt_q + 8'h01;
	end

endmodule : glitch_filter

// File: verilog/tamper_alarm_monitor.sv
`timescale 1ns/10ps
`include "tamper_cfg.svh"

// Overview of operation
// - Any tamper input off idle asserts alarm.
// - Alarm releases when no condition remains.
// - Inputs a and c: low is tamper.
// - Inputs b and d: high is tamper.
// - Over or under voltage asserts alarm.
// - Each tamper input is glitch filtered.
// - Alarm low regardless; supply follows variant.
// - Detection disabled until first valid power-up.
// - Once armed, detect on main or battery.
// - Variants: on/normal, hiz/high, ground/high.
// - Time-out restarts whenever supply drops before arming.
module tamper_alarm_monitor
#(
	parameter int unsigned RESET_TIMEOUT_CYCLES = `RESET_TIMEOUT_CYC
)
(
	input  wire logic                        clk,                   // 20 MHz clock.
	input  wire logic                        rst_n,                 // Sync reset, low.
	input  wire logic                        tamper_in_a_idle_high, // Idles high.
	input  wire logic                        tamper_in_b_idle_low,  // Idles low.
	input  wire logic                        tamper_in_c_idle_high, // Idles high.
	input  wire logic                        tamper_in_d_idle_low,  // Idles low.
	input  wire logic                        overvoltage_trip,      // Supply over limit.
	input  wire logic                        undervoltage_trip,     // Supply under limit.
	input  wire logic                        main_above_reset,      // Main supply valid.
	input  wire logic                        on_battery,            // Switched to battery.
	input  wire tamper_pkg::supply_variant_e variant,               // Alarm supply mode.
	input  wire logic [7:0]                  filter_count,          // Stable samples.
	output logic                             security_alarm_n,      // Alarm, active low.
	output logic                             supply_on,             // Supply switch closed.
	output logic                             supply_gnd,            // Supply pulled to ground.
	output logic                             switch_ind,            // Battery indicator.
	output logic                             detect_armed           // Detection armed.
);
	import tamper_pkg::*;

	logic [3:0]  raw_vec;
	logic [3:0]  filt_vec;
	logic [1:0]  volt_s1_q;
	logic [1:0]  volt_s2_q;
	logic        main_s1_q;
	logic        main_s2_q;
	logic [31:0] timeout_q;
	arm_state_e  arm_q;
	logic        tamper_now;
	logic        idle_high_polarity;
	logic        idle_low_polarity;

	// ------------------------------------------------------------
	// Input qualification
	// ------------------------------------------------------------
	// Idle-high inputs a and c are flipped so that a set bit always means tamper.
	assign raw_vec[`TAMPER_A_BIT] = ~tamper_in_a_idle_high;
	assign raw_vec[`TAMPER_C_BIT] = ~tamper_in_c_idle_high;
	assign raw_vec[`TAMPER_B_BIT] = tamper_in_b_idle_low;
	assign raw_vec[`TAMPER_D_BIT] = tamper_in_d_idle_low;

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_filt
			glitch_filter u_filt
			(
				.clk        (clk),
				.rst_n      (rst_n),
				.raw_in     (raw_vec[g]),
				.reset_val  (1'b0),
				.stable_cnt (filter_count),
				.filt_out   (filt_vec[g])
			);
		end
	endgenerate

	// Comparator flags and main-supply level are synchronised too.
	always_ff @(posedge clk)
	begin
		volt_s1_q <= {overvoltage_trip, undervoltage_trip};
		volt_s2_q <= volt_s1_q;
		main_s1_q <= main_above_reset;
		main_s2_q <= main_s1_q;
	end

	assign idle_high_polarity = filt_vec[`TAMPER_A_BIT] | filt_vec[`TAMPER_C_BIT];
	assign idle_low_polarity  = filt_vec[`TAMPER_B_BIT] | filt_vec[`TAMPER_D_BIT];

	// ------------------------------------------------------------
	// Arming after first valid power-up
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			arm_q     <= ARM_COLD;
			timeout_q <= 32'h0000_0000;
		end
		else
		begin
			case (arm_q)
				ARM_COLD:
				begin
					timeout_q <= 32'h0000_0000;
					if (main_s2_q)
						arm_q <= ARM_TIMEOUT;
				end
				ARM_TIMEOUT:
				begin
					if (!main_s2_q)
					begin
						timeout_q <= 32'h0000_0000;
						arm_q     <= ARM_COLD;
					end
					else if (timeout_q >= RESET_TIMEOUT_CYCLES - 1)
						arm_q <= ARM_ARMED;
					else
						timeout_q <= timeout_q + 32'h0000_0001;
				end
				// Armed state is kept on battery as well as main supply.
				ARM_ARMED: arm_q <= ARM_ARMED;
				default:   arm_q <= ARM_COLD;
			endcase
		end
	end

	assign detect_armed = (arm_q == ARM_ARMED);

	// ------------------------------------------------------------
	// Alarm and supply output
	// ------------------------------------------------------------
	assign tamper_now = detect_armed &
		(idle_high_polarity | idle_low_polarity | (|volt_s2_q));

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			security_alarm_n <= 1'b1;
			supply_on        <= 1'b1;
			supply_gnd       <= 1'b0;
			switch_ind       <= 1'b0;
		end
		else
		begin
			security_alarm_n <= ~tamper_now;
			supply_on        <= 1'b1;
			supply_gnd       <= 1'b0;
			switch_ind       <= on_battery;
			if (tamper_now)
			begin
				case (variant)
					VARIANT_ON: ;
					VARIANT_HIZ:
					begin
						supply_on  <= 1'b0;
						switch_ind <= 1'b1;
					end
					VARIANT_GND:
					begin
						supply_on  <= 1'b0;
						supply_gnd <= 1'b1;
						switch_ind <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

endmodule : tamper_alarm_monitor
